// file: eqa_pkg.sv
package eqa_pkg;
	localparam int EQA_DEPTH       = 20;
	localparam int EQA_CODE_W      = 16;
	localparam int EQA_MSG_W       = 8;
	localparam int EQA_MSG_MAX     = 80;
	localparam logic [15:0] EQA_CODE_NONE     = 16'h0000;
	localparam logic [15:0] EQA_CODE_OVERFLOW = 16'hFEA2;
	localparam logic [7:0]  EQA_MSG_ID_NONE   = 8'h00;
	localparam logic [7:0]  EQA_MSG_ID_OVER   = 8'hFF;
	localparam logic EQA_BEEP_EN_RST  = 1'b1;
	localparam logic EQA_DISP_ON_RST  = 1'b1;
	localparam logic EQA_TEST_PASS    = 1'b0;
	localparam logic EQA_TEST_FAIL    = 1'b1;
	localparam real  EQA_CLK_MHZ      = 100.0;
	localparam real  EQA_BEEP_US      = 100.0;
	localparam int   EQA_BEEP_CYC     = int'(EQA_BEEP_US * EQA_CLK_MHZ);
	localparam int   EQA_BEEP_CNT_W   = 16;
endpackage : eqa_pkg

// file: eqa_beep_gen.sv
`timescale 1ns/1ns
module eqa_beep_gen #(
	parameter int BEEP_CYC = eqa_pkg::EQA_BEEP_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clkEn,
	// trigger and tone
	input  wire logic beepTrig,
	output logic      beepOut
);
	import eqa_pkg::*;

	logic [EQA_BEEP_CNT_W-1:0] cnt_r;
	wire  cntBusy = (cnt_r != '0);
	wire  [EQA_BEEP_CNT_W-1:0] cnt_nxt = beepTrig ? EQA_BEEP_CNT_W'(BEEP_CYC) :
		(cntBusy ? cnt_r - 1'b1 : cnt_r);

	// a retrigger restarts the tone; overlapping events merge into one beep
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r   <= '0;
			beepOut <= 1'b0;
		end else if (clkEn) begin
			cnt_r   <= cnt_nxt;
			beepOut <= (cnt_nxt != '0);
		end
	end
endmodule : eqa_beep_gen

// file: eqa_error_queue.sv
`timescale 1ns/1ns
module eqa_error_queue #(
	parameter int DEPTH    = eqa_pkg::EQA_DEPTH,
	parameter int CODE_W   = eqa_pkg::EQA_CODE_W,
	parameter int MSG_W    = eqa_pkg::EQA_MSG_W,
	parameter int BEEP_CYC = eqa_pkg::EQA_BEEP_CYC
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              clkEn,
	// error sources
	input  wire logic              errPush,
	input  wire logic [CODE_W-1:0] errCode,
	input  wire logic [MSG_W-1:0]  errMsgId,
	// readout
	input  wire logic              errPop,
	output logic                   rdValid,
	output logic      [CODE_W-1:0] rdCode,
	output logic      [MSG_W-1:0]  rdMsgId,
	// clearing
	input  wire logic              clearStatus,
	input  wire logic              menuParamView,
	input  wire logic              menuExit,
	// self-test
	input  wire logic              testDone,
	input  wire logic              testFailed,
	output logic                   testResult,
	output logic                   testFailLamp,
	// beeper
	input  wire logic              hostBeep,
	input  wire logic              beepSetValid,
	input  wire logic              beepSetOn,
	input  wire logic              toneMinMax,
	input  wire logic              toneHold,
	input  wire logic              toneLimit,
	input  wire logic              toneDiode,
	input  wire logic              toneContinuity,
	output logic                   beepEnabled,
	output logic                   beepOut,
	// display lamps
	input  wire logic              displayOnSet,
	input  wire logic              displayOnValid,
	input  wire logic              shiftActive,
	input  wire logic [7:0]        otherLamps,
	output logic                   errorLamp,
	output logic                   shiftLamp,
	output logic      [7:0]        otherLampsOut,
	output logic      [4:0]        entryCount
);
	import eqa_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// storage
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	// arrays carry no reset: pointers and count alone say which words are live
	// twenty entries
	logic [CODE_W-1:0] codeMem [DEPTH];
	logic [MSG_W-1:0]  msgMem  [DEPTH];
	logic [PTR_W-1:0]  head_r;
	logic [PTR_W-1:0]  tail_r;
	logic [CNT_W-1:0]  count_r;
	logic              overflow_r;
	logic              viewedErr_r;
	logic              testFail_r;
	logic              beepEn_r;
	logic              dispOn_r;

	function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
		ptrInc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptrInc

	function automatic logic [PTR_W-1:0] ptrDec(input logic [PTR_W-1:0] p);
		ptrDec = (p == '0) ? PTR_W'(DEPTH - 1) : p - 1'b1;
	endfunction : ptrDec

	////////////////////////////////////////////////////////////////////////////////
	// decode
	// menu exit clear
	wire menuClear = menuExit & viewedErr_r;
	// a clear beats any push or pop landing in the same cycle
	// clear status empties
	wire clearAll  = clearStatus | menuClear;
	wire isEmpty   = (count_r == '0);
	wire doPop     = errPop & ~isEmpty & ~clearAll;
	wire [CNT_W-1:0] cntAfterPop = doPop ? count_r - 1'b1 : count_r;
	wire fullAfter = (cntAfterPop == CNT_W'(DEPTH));
	// drop while overflowed; a pop this cycle lifts it
	wire ovfAfterPop = overflow_r & ~doPop;
	wire doStore   = errPush & ~clearAll & ~fullAfter & ~ovfAfterPop;
	wire doOvf     = errPush & ~clearAll & fullAfter & ~ovfAfterPop;
	wire [PTR_W-1:0] newestPtr = ptrDec(tail_r);

	wire [PTR_W-1:0] head_nxt  = clearAll ? '0 : (doPop ? ptrInc(head_r) : head_r);
	wire [PTR_W-1:0] tail_nxt  = clearAll ? '0 : (doStore ? ptrInc(tail_r) : tail_r);
	wire [CNT_W-1:0] count_nxt = clearAll ? '0 : (doStore ? cntAfterPop + 1'b1 : cntAfterPop);
	wire overflow_nxt = clearAll ? 1'b0 : (doOvf | ovfAfterPop);
	// fail flag set wins over clear
	wire testFail_nxt = testDone ? testFailed : (testFail_r & ~clearAll);

	////////////////////////////////////////////////////////////////////////////////
	// queue state
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			head_r      <= '0;
			tail_r      <= '0;
			count_r     <= '0;
			overflow_r  <= 1'b0;
			viewedErr_r <= 1'b0;
		end else if (clkEn) begin
			head_r      <= head_nxt;
			tail_r      <= tail_nxt;
			count_r     <= count_nxt;
			overflow_r  <= overflow_nxt;
			viewedErr_r <= menuExit ? 1'b0 : (viewedErr_r | menuParamView);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clkEn & doStore) begin
			codeMem[tail_r] <= errCode;
			msgMem[tail_r]  <= errMsgId;
		end else if (clkEn & doOvf) begin
			codeMem[newestPtr] <= CODE_W'(EQA_CODE_OVERFLOW);
			msgMem[newestPtr]  <= MSG_W'(EQA_MSG_ID_OVER);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// readout
	// oldest first
	wire [CODE_W-1:0] popCode = isEmpty ? CODE_W'(EQA_CODE_NONE) : codeMem[head_r];
	wire [MSG_W-1:0]  popMsg  = isEmpty ? MSG_W'(EQA_MSG_ID_NONE) : msgMem[head_r];

	// answer holds until the next query, so a slow reader still finds it
	// one entry per query
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdValid <= 1'b0;
			rdCode  <= '0;
			rdMsgId <= '0;
		end else if (clkEn) begin
			rdValid <= errPop;
			if (errPop) begin
				rdCode  <= popCode;
				rdMsgId <= popMsg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// self-test, beeper enable, display state
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			testFail_r <= 1'b0;
			testResult <= EQA_TEST_PASS;
			beepEn_r   <= EQA_BEEP_EN_RST;
			dispOn_r   <= EQA_DISP_ON_RST;
		end else if (clkEn) begin
			testFail_r <= testFail_nxt;
			if (testDone)
				testResult <= testFailed ? EQA_TEST_FAIL : EQA_TEST_PASS;
			// enable kept; only the power reset restores it
			if (beepSetValid)
				beepEn_r <= beepSetOn;
			if (displayOnValid)
				dispOn_r <= displayOnSet;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// tones
	// one beep per error, ungated
	wire errBeep  = errPush;
	wire gatedTone = beepEn_r & (toneMinMax | toneHold | toneLimit | toneDiode);
	// menu exit and continuity beep even with the beeper off
	wire beepTrig  = errBeep | hostBeep | toneContinuity | menuExit | gatedTone;

	eqa_beep_gen #(
		.BEEP_CYC (BEEP_CYC)
	) u_beep (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.beepTrig (beepTrig),
		.beepOut  (beepOut)
	);

	////////////////////////////////////////////////////////////////////////////////
	// lamps
	// lamp tracks queue and failed self-test
	wire lamp_nxt = (count_nxt != '0) | testFail_nxt;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			errorLamp     <= 1'b0;
			shiftLamp     <= 1'b0;
			otherLampsOut <= '0;
			beepEnabled   <= EQA_BEEP_EN_RST;
			testFailLamp  <= 1'b0;
			entryCount    <= '0;
		end else if (clkEn) begin
			errorLamp     <= lamp_nxt;
			shiftLamp     <= shiftActive;
			// blank all but error, shift and test-fail lamps
			otherLampsOut <= dispOn_r ? otherLamps : 8'h00;
			beepEnabled   <= beepSetValid ? beepSetOn : beepEn_r;
			testFailLamp  <= testFail_nxt;
			entryCount    <= 5'(count_nxt);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_count_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
		count_r <= CNT_W'(DEPTH)) else $error("queue count above depth");
	a_empty_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && errPop && isEmpty && !clearAll |=> rdValid && rdCode == CODE_W'(EQA_CODE_NONE))
		else $error("empty read not answered with no error");
	a_pop_oldest: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && doPop |=> rdCode == $past(codeMem[head_r]))
		else $error("pop did not return oldest entry");
	a_lamp_track: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn |=> errorLamp == ((count_r != '0) | testFail_r))
		else $error("error lamp does not follow queue");
	a_ovf_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && overflow_r && !doPop && !clearAll |=> count_r == $past(count_r))
		else $error("entry stored while overflowed");
	a_ovf_mark: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && doOvf |=> codeMem[$past(newestPtr)] == EQA_CODE_OVERFLOW && overflow_r)
		else $error("overflow code not written");
	a_clear_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && clearStatus |=> count_r == '0 && !overflow_r)
		else $error("clear status left entries");
	a_err_beep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && errPush |=> beepOut) else $error("error produced no beep");
	a_muted_tone: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && !beepEn_r && !beepOut && !errPush && !hostBeep && !toneContinuity && !menuExit
		|=> !beepOut) else $error("muted tone sounded");
	a_lamp_blank: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && !dispOn_r |=> otherLampsOut == 8'h00) else $error("lamps not blanked");
	a_menu_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && menuClear |=> count_r == '0) else $error("menu exit did not clear");
	a_test_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && testDone |=> testResult == $past(testFailed) && testFailLamp == $past(testFailed))
		else $error("self-test answer wrong");

	////////////////////////////////////////////////////////////////////////////////
	// checks on strobes, counts, lamps and tones
	a_rd_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn |=> rdValid == $past(errPop)) else $error("answer strobe does not follow query");
	a_beep_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && beepSetValid |=> beepEnabled == $past(beepSetOn))
		else $error("beeper enable not taken");
	a_host_beep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && hostBeep |=> beepOut) else $error("host beep not sounded");
	a_push_pop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && doPop && errPush |=> count_r == $past(count_r))
		else $error("push with pop changed the count");
	a_push_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && errPush && !errPop && !clearAll && !overflow_r && count_r != CNT_W'(DEPTH)
		|=> count_r == $past(count_r) + 1'b1) else $error("push not stored");
	a_pop_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && doPop && !errPush |=> count_r == $past(count_r) - 1'b1)
		else $error("pop did not remove one entry");
	a_empty_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && errPop && isEmpty && !errPush |=> count_r == '0)
		else $error("empty read changed the queue");
	a_ovf_pop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && overflow_r && doPop |=> !overflow_r) else $error("overflow not lifted by a read");
	a_menu_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && menuExit && !viewedErr_r && !clearStatus && !errPop && !errPush
		|=> count_r == $past(count_r)) else $error("menu exit without viewing cleared");
	a_test_lamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && testFail_r && !clearAll && !testDone |=> errorLamp)
		else $error("failed self-test lamp dropped");
	a_shift_lamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn |=> shiftLamp == $past(shiftActive)) else $error("shift lamp not driven");
	a_cont_tone: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && toneContinuity |=> beepOut) else $error("continuity tone muted");
	a_gated_tone: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && beepEn_r && toneMinMax |=> beepOut) else $error("enabled tone not sounded");
endmodule : eqa_error_queue

// file: eqa_host_model.sv
`timescale 1ns/1ns
module eqa_host_model (
	// clock
	input  wire logic        clk_sys,
	// answer from the queue
	input  wire logic        rdValid,
	input  wire logic [15:0] rdCode,
	input  wire logic [7:0]  rdMsgId,
	// host requests
	output logic             errPop,
	output logic             hostBeep,
	output logic             beepSetValid,
	output logic             beepSetOn
);
	initial begin
		errPop       = 1'h0;
		hostBeep     = 1'h0;
		beepSetValid = 1'h0;
		beepSetOn    = 1'h0;
	end
	////////////////////////////////////////////////////////////
	// one query pops one entry
	task automatic query(output logic v, output logic [23:0] ans);
		@(negedge clk_sys);
		errPop = 1'h1;
		@(negedge clk_sys);
		errPop = 1'h0;
		v      = rdValid;
		ans    = {rdCode, rdMsgId};
	endtask : query
	task automatic setBeep(input logic on);
		@(negedge clk_sys);
		beepSetValid = 1'h1;
		beepSetOn    = on;
		@(negedge clk_sys);
		beepSetValid = 1'h0;
		// value flipped once the qualifier drops, so a stale value cannot pass
		beepSetOn    = ~on;
	endtask : setBeep
	task automatic beepNow();
		@(negedge clk_sys);
		hostBeep = 1'h1;
		@(negedge clk_sys);
		hostBeep = 1'h0;
	endtask : beepNow
endmodule : eqa_host_model

// file: error_queue_and_alerts_tb.sv
`timescale 1ns/1ns
module error_queue_and_alerts_tb;
	import eqa_pkg::*;
	// ctl bits: clear, view, exit, test done, display set, continuity, four gated tones
	localparam logic [9:0] CLS = 10'h001, VIEW = 10'h002, EXIT = 10'h004, TDONE = 10'h008, DISP = 10'h010;
	logic        clk_sys = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, errPush = 1'h0, testFailed = 1'h0;
	logic        displayOnSet = 1'h1, shiftActive = 1'h1, v;
	logic [9:0]  ctl = 10'h000;
	logic [15:0] errCode = 16'h0000, rdCode;
	logic [7:0]  errMsgId = 8'h00, otherLamps = 8'hA5, rdMsgId, otherLampsOut;
	logic        errPop, hostBeep, beepSetValid, beepSetOn, rdValid, testResult, testFailLamp;
	logic        beepEnabled, beepOut, errorLamp, shiftLamp;
	logic [4:0]  entryCount;
	logic [23:0] a;
	int          error_cnt = 0, checks = 0;

	always #5 clk_sys = ~clk_sys;

	eqa_error_queue #(.BEEP_CYC(4)) dut_u (
		.clk_sys, .sys_rst, .clkEn, .errPush, .errCode, .errMsgId, .errPop, .rdValid, .rdCode, .rdMsgId,
		.clearStatus(ctl[0]), .menuParamView(ctl[1]), .menuExit(ctl[2]), .testDone(ctl[3]), .testFailed,
		.testResult, .testFailLamp, .hostBeep, .beepSetValid, .beepSetOn, .toneMinMax(ctl[6]),
		.toneHold(ctl[7]), .toneLimit(ctl[8]), .toneDiode(ctl[9]), .toneContinuity(ctl[5]), .beepEnabled,
		.beepOut, .displayOnSet, .displayOnValid(ctl[4]), .shiftActive, .otherLamps, .errorLamp, .shiftLamp,
		.otherLampsOut, .entryCount
	);
	eqa_host_model host_u (.clk_sys, .rdValid, .rdCode, .rdMsgId, .errPop, .hostBeep, .beepSetValid, .beepSetOn);

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic pulse(input logic [9:0] m);
		@(negedge clk_sys);
		ctl = m;
		@(negedge clk_sys);
		ctl = 10'h000;
	endtask : pulse
	task automatic push(input logic [15:0] c, input logic [7:0] m);
		@(negedge clk_sys);
		errPush  = 1'h1;
		errCode  = c;
		errMsgId = m;
		@(negedge clk_sys);
		errPush  = 1'h0;
		errCode  = ~c;
		errMsgId = ~m;
	endtask : push
	task automatic pop(input logic [23:0] e);
		host_u.query(v, a);
		chk(v, 1'h1, "rdValid");
		chk(a, e, "entry");
	endtask : pop
	////////////////////////////////////////////////////////////
	task automatic t_fifo();
		push(16'hFF8F, 8'h01);
		push(16'hFF9C, 8'h02);
		push(16'h0005, 8'h03);
		chk({errorLamp, entryCount}, 6'h23, "three held");
		pop({16'hFF8F, 8'h01});
		pop({16'hFF9C, 8'h02});
		pop({16'h0005, 8'h03});
		chk(errorLamp, 1'h0, "lamp off");
		pop({EQA_CODE_NONE, EQA_MSG_ID_NONE});
		chk({errorLamp, entryCount}, 6'h00, "empty kept");
	endtask : t_fifo
	task automatic t_ovf();
		// 22 pushes: the 21st overwrites the newest, the 22nd must vanish
		for (int i = 0; i < 22; i++) begin
			push(16'h0100 + 16'(i), 8'(i));
		end
		chk(entryCount, 5'h14, "full");
		pop({16'h0100, 8'h00});
		push(16'h0200, 8'h20);
		chk(entryCount, 5'h14, "refill");
		for (int i = 1; i < 19; i++) begin
			pop({16'h0100 + 16'(i), 8'(i)});
		end
		pop({16'hFEA2, 8'hFF});
		pop({16'h0200, 8'h20});
	endtask : t_ovf
	task automatic t_clear();
		push(16'hFF90, 8'h04);
		pulse(CLS);
		chk({errorLamp, entryCount}, 6'h00, "cls");
		push(16'hFF90, 8'h04);
		pulse(EXIT);
		chk(entryCount, 5'h1, "exit only");
		pulse(VIEW);
		pulse(EXIT);
		chk(entryCount, 5'h0, "menu clear");
		push(16'hFF90, 8'h04);
		@(negedge clk_sys);
		sys_rst = 1'h1;
		@(negedge clk_sys);
		sys_rst = 1'h0;
		chk({errorLamp, entryCount}, 6'h00, "power loss");
	endtask : t_clear
	task automatic t_beep();
		host_u.setBeep(1'h0);
		chk(beepEnabled, 1'h0, "beep off");
		for (int i = 0; i < 4; i++) begin
			pulse(10'h040 << i);
			chk(beepOut, 1'h0, "muted");
		end
		pulse(10'h020);
		chk(beepOut, 1'h1, "continuity");
		repeat (6) @(negedge clk_sys);
		pulse(EXIT);
		chk(beepOut, 1'h1, "menu exit");
		repeat (6) @(negedge clk_sys);
		push(16'hFF8F, 8'h01);
		chk(beepOut, 1'h1, "error beep");
		repeat (6) @(negedge clk_sys);
		host_u.beepNow();
		chk(beepOut, 1'h1, "host beep");
		host_u.setBeep(1'h1);
		repeat (6) @(negedge clk_sys);
		pulse(10'h040);
		chk({beepEnabled, beepOut}, 2'h3, "tone on");
		pop({16'hFF8F, 8'h01});
	endtask : t_beep
	task automatic t_test();
		testFailed = 1'h1;
		pulse(TDONE);
		chk({testResult, testFailLamp, errorLamp}, 3'h7, "fail");
		testFailed = 1'h0;
		pulse(TDONE);
		chk({testResult, errorLamp}, 2'h0, "pass");
		// with the clock enable low a push must leave no trace
		clkEn = 1'h0;
		push(16'h0033, 8'h33);
		chk({errorLamp, entryCount}, 6'h00, "frozen");
		clkEn = 1'h1;
	endtask : t_test
	task automatic t_disp();
		// display state reaches the lamps one cycle after it is taken
		displayOnSet = 1'h0;
		pulse(DISP);
		@(negedge clk_sys);
		chk({shiftLamp, otherLampsOut}, 9'h100, "blank");
		shiftActive = 1'h0;
		@(negedge clk_sys);
		chk(shiftLamp, 1'h0, "shift follows");
		shiftActive = 1'h1;
		push(16'h0011, 8'h11);
		chk(errorLamp, 1'h1, "err lamp");
		displayOnSet = 1'h1;
		pulse(DISP);
		@(negedge clk_sys);
		chk(otherLampsOut, 8'hA5, "lamps back");
		// push and pop in one cycle: the old entry leaves, the new one stays
		fork
			pop({16'h0011, 8'h11});
			push(16'h0022, 8'h22);
		join
		chk(entryCount, 5'h1, "pop then push");
		pop({16'h0022, 8'h22});
	endtask : t_disp
	////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'h0;
		chk(beepEnabled, EQA_BEEP_EN_RST, "beep default");
		t_fifo();
		t_ovf();
		t_clear();
		t_beep();
		t_test();
		t_disp();
		finish_test();
	end
	// whole run is under two hundred cycles; this bound only catches a hang
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end
endmodule : error_queue_and_alerts_tb
